//--- rtl/dtws_defines.svh
// dtws_defines.svh: bus addresses, subaddresses, field positions, resets, timing
// assumes: included by the storage design files by bare name
`ifndef DTWS_DEFINES_SVH
`define DTWS_DEFINES_SVH

`define DTWS_ADDR_WR_PORT 8'h7A
`define DTWS_ADDR_WR_SEL 8'h7B
`define DTWS_ADDR_RD_PORT 8'hFA
`define DTWS_ADDR_RD_AUX 8'hFB

`define DTWS_SUB_MODE 3'h0
`define DTWS_SUB_THRESH 3'h1
`define DTWS_SUB_KOFS 3'h2
`define DTWS_SUB_PTR_LO 3'h3
`define DTWS_SUB_PTR_HI 3'h4
`define DTWS_SUB_TBL_DATA 3'h5

`define DTWS_MODE_SHOW_A 0
`define DTWS_MODE_SHOW_B 1
`define DTWS_MODE_FREEZE_A 2
`define DTWS_MODE_DIFF 3
`define DTWS_MODE_MAXHOLD 4
`define DTWS_SEL_HALF_BIT 7

`define DTWS_MODE_RST 8'h03
`define DTWS_THRESH_RST 8'h80
`define DTWS_KOFS_RST 8'h80
`define DTWS_SEL_RST 8'h80

`define DTWS_TABLE_PTS 500
`define DTWS_DISP_LAST 10'h3E7
`define DTWS_MIN_SAMPLES 18'h00002
`define DTWS_MAX_SAMPLES 18'h20000

`define DTWS_CLK_NS 8
`define DTWS_PHI2_NS 1000
`define DTWS_PHI2_CYC (`DTWS_PHI2_NS / `DTWS_CLK_NS)

`endif

//--- rtl/dtws_pkg.sv
// dtws_pkg.sv: types shared by the storage design files
// assumes: nothing outside itself
package dtws_pkg;
   typedef enum logic [1:0] {
      dtws_st_acc = 2'b00,
      dtws_st_div = 2'b01,
      dtws_st_emit = 2'b10
   } dtws_red_st_t;
endpackage

//--- rtl/dtws_smp_if.sv
// dtws_smp_if.sv: reduced point (position and value) with valid and ready
// assumes: one clock shared by both ends
`timescale 1ns/10ps
interface dtws_smp_if;
   logic valid;
   logic ready;
   logic [9:0] x;
   logic [7:0] y;
   modport src (output valid, output x, output y, input ready);
   modport snk (input valid, input x, input y, output ready);
endinterface

//--- rtl/dtws_buf.sv
// dtws_buf.sv: two-entry buffer between reduction and table writer
// assumes: single clock, asynchronous active-high reset
`timescale 1ns/10ps
module dtws_buf (
   input wire logic clk_i,
   input wire logic rst_i,
   dtws_smp_if.snk in_if,
   dtws_smp_if.src out_if
);
   logic [17:0] ent_ff [0:1];
   logic [1:0] cnt_ff;
   logic push;
   logic pop;

   assign in_if.ready = (cnt_ff != 2'h2);
   assign out_if.valid = (cnt_ff != 2'h0);
   assign out_if.x = ent_ff[0][17:8];
   assign out_if.y = ent_ff[0][7:0];
   assign push = in_if.valid && in_if.ready;
   assign pop = out_if.valid && out_if.ready;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_ff <= 2'h0;
      end else begin
         cnt_ff <= 2'(cnt_ff + {1'b0, push} - {1'b0, pop});
      end
   end

   // entry 0 is always the head; a pop shifts entry 1 down
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ent_ff[0] <= 18'h00000;
         ent_ff[1] <= 18'h00000;
      end else begin
         if (pop) begin
            ent_ff[0] <= ent_ff[1];
         end
         if (push) begin
            ent_ff[1'(cnt_ff - {1'b0, pop})] <= {in_if.x, in_if.y};
         end
      end
   end

   property p_buf_hold;
      @(posedge clk_i) disable iff (rst_i)
      (out_if.valid && !out_if.ready)
         |=> (out_if.valid && $stable(out_if.y) && $stable(out_if.x));
   endproperty
   a_buf_hold: assert property (p_buf_hold) else $error("buffer head changed while stalled");
endmodule // dtws_buf

//--- rtl/dtws_reduce.sv
// dtws_reduce.sv: per-position peak and average reduction of converted samples
// assumes: samples spaced by at least a conversion time, single clock
`timescale 1ns/10ps
`include "dtws_defines.svh"
module dtws_reduce (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic smp_valid_i,
   input wire logic [7:0] smp_y_i,
   input wire logic [9:0] smp_x_i,
   input wire logic pas_i,
   dtws_smp_if.src out_if
);
   dtws_pkg::dtws_red_st_t st_ff;
   logic [24:0] sum_ff;
   logic [17:0] cnt_ff;
   logic [7:0] peak_ff;
   logic pas_ff;
   logic [9:0] x_ff;
   logic [24:0] rem_ff;
   logic [17:0] den_ff;
   logic [7:0] res_ff;
   logic [9:0] rx_ff;
   logic [2:0] bit_ff;
   logic [25:0] trial;
   logic close;

   // a position closes only once it holds the least sample count
   assign close = smp_valid_i && (smp_x_i != x_ff) && (cnt_ff >= `DTWS_MIN_SAMPLES)
      && (st_ff == dtws_pkg::dtws_st_acc);
   assign trial = {1'b0, rem_ff} - (26'(den_ff) << bit_ff);
   assign out_if.valid = (st_ff == dtws_pkg::dtws_st_emit);
   assign out_if.x = rx_ff;
   assign out_if.y = res_ff;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sum_ff <= 25'h0000000;
         cnt_ff <= 18'h00000;
         peak_ff <= 8'h00;
         pas_ff <= 1'b0;
         x_ff <= 10'h000;
      end else if (close) begin
         sum_ff <= 25'(smp_y_i);
         cnt_ff <= 18'h00001;
         peak_ff <= smp_y_i;
         pas_ff <= pas_i;
         x_ff <= smp_x_i;
      end else if (smp_valid_i && cnt_ff != `DTWS_MAX_SAMPLES) begin
         sum_ff <= 25'(sum_ff + 25'(smp_y_i));
         cnt_ff <= 18'(cnt_ff + 18'h00001);
         peak_ff <= (smp_y_i > peak_ff) ? smp_y_i : peak_ff;
         pas_ff <= pas_ff | pas_i;
         x_ff <= (cnt_ff == 18'h00000) ? smp_x_i : x_ff;
      end
   end

   // serial restoring divide, msb first, eight quotient bits
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_ff <= dtws_pkg::dtws_st_acc;
         rem_ff <= 25'h0000000;
         den_ff <= 18'h00000;
         res_ff <= 8'h00;
         rx_ff <= 10'h000;
         bit_ff <= 3'h7;
      end else begin
         unique case (st_ff)
            dtws_pkg::dtws_st_acc: begin
               if (close) begin
                  rem_ff <= sum_ff;
                  den_ff <= cnt_ff;
                  rx_ff <= x_ff;
                  bit_ff <= 3'h7;
                  res_ff <= peak_ff;
                  // with pas_ff set the peak is stored, else the mean
                  st_ff <= pas_ff ? dtws_pkg::dtws_st_emit : dtws_pkg::dtws_st_div;
               end
            end
            dtws_pkg::dtws_st_div: begin
               res_ff[bit_ff] <= !trial[25];
               if (!trial[25]) begin
                  rem_ff <= trial[24:0];
               end
               bit_ff <= 3'(bit_ff - 3'h1);
               if (bit_ff == 3'h0) begin
                  st_ff <= dtws_pkg::dtws_st_emit;
               end
            end
            dtws_pkg::dtws_st_emit: begin
               if (out_if.ready) begin
                  st_ff <= dtws_pkg::dtws_st_acc;
               end
            end
            default: begin
               st_ff <= dtws_pkg::dtws_st_acc;
            end
         endcase
      end
   end

   property p_peak_pass;
      @(posedge clk_i) disable iff (rst_i)
      (close && pas_ff) |=> (out_if.valid && out_if.y == $past(peak_ff));
   endproperty
   a_peak_pass: assert property (p_peak_pass) else $error("peak not passed through");

   property p_avg_time;
      @(posedge clk_i) disable iff (rst_i)
      (close && !pas_ff) |=> !out_if.valid [*8] ##1 out_if.valid;
   endproperty
   a_avg_time: assert property (p_avg_time) else $error("average not ready in 8 cycles");

   property p_min_cnt;
      @(posedge clk_i) disable iff (rst_i)
      (st_ff == dtws_pkg::dtws_st_acc && smp_valid_i && smp_x_i != x_ff
         && cnt_ff < `DTWS_MIN_SAMPLES) |=> (st_ff == dtws_pkg::dtws_st_acc);
   endproperty
   a_min_cnt: assert property (p_min_cnt) else $error("position closed with one sample");
endmodule // dtws_reduce

//--- rtl/dtws_top.sv
// dtws_top.sv: dual-table waveform storage, bus decode, tables, display scan
// assumes: bus strobes and sweep inputs synchronous to clk_i
`timescale 1ns/10ps
`include "dtws_defines.svh"

////////////////////////////////////////////////////////////////////////////////
// What this block does
// - two independent 500-point waveform tables
// - max hold keeps highest value per position
// - freeze-A stops table A updates
// - difference mode shows B minus A
// - table B rewritten every sweep
// - table B offset half step, interleaved
// - frozen both: two traces; else merged
// - two to 2^17 samples per position
// - reduce to peak or mean
// - select signal picks peak or average
// - cursor cycle outputs threshold level
// - pause display where sweep equals position
// - decode exactly addresses 7A 7B FA FB
// - 7A split by 3-bit subaddress
// - half select picks responding half
// - sweep value chooses table entry
// - view modes show tables unprocessed
// - display scan timed from 1 MHz tick
module dtws_top (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] bus_addr_i,
   input wire logic [7:0] bus_data_i,
   input wire logic bus_wr_i,
   input wire logic bus_rd_i,
   output logic [7:0] bus_data_o,
   output logic bus_data_oe_o,
   input wire logic [9:0] sweep_x_i,
   input wire logic smp_valid_i,
   input wire logic [7:0] smp_y_i,
   input wire logic peak_average_select_i,
   input wire logic cursor_cycle_i,
   output logic [9:0] disp_x_o,
   output logic [7:0] disp_y_o,
   output logic disp_blank_o,
   output logic disp_trace_o,
   output logic disp_pause_o
);
   ////////////////////////////////////////////////////////////////////////////
   // declarations
   logic [7:0] mem_a [0:`DTWS_TABLE_PTS-1];
   logic [7:0] mem_b [0:`DTWS_TABLE_PTS-1];
   logic [7:0] mode_ff;
   logic [7:0] sel_ff;
   logic [7:0] thresh_ff;
   logic [7:0] kofs_ff;
   logic [9:0] ptr_ff;
   logic [7:0] rdata_ff;
   logic oe_ff;
   logic [6:0] tick_cnt_ff;
   logic tick;
   logic [9:0] dcnt_ff;
   logic trace_ff;
   logic [9:0] nxt_disp_x;
   logic [7:0] nxt_disp_y;
   logic nxt_blank;
   logic wr_sel;
   logic wr_port;
   logic rd_hit;
   logic vert;
   logic host_tbl_wr;
   logic wr_accept;
   logic wa_en;
   logic wb_en;
   logic [8:0] wr_idx;
   logic [7:0] old_a;
   logic [7:0] old_b;
   logic [7:0] new_a;
   logic [7:0] new_b;
   logic [8:0] hp_idx;
   logic [8:0] d_idx;
   logic [7:0] da;
   logic [7:0] db;
   logic [9:0] diff;
   logic freeze;
   logic pause;
   dtws_smp_if red_if ();
   dtws_smp_if wr_if ();

   ////////////////////////////////////////////////////////////////////////////
   // acquisition path: reduction, then a two-entry buffer before the tables
   dtws_reduce u_reduce (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .smp_valid_i(smp_valid_i),
      .smp_y_i(smp_y_i),
      .smp_x_i(sweep_x_i),
      .pas_i(peak_average_select_i),
      .out_if(red_if.src)
   );

   dtws_buf u_buf (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .in_if(red_if.snk),
      .out_if(wr_if.src)
   );

   ////////////////////////////////////////////////////////////////////////////
   // bus decode
   assign wr_port = bus_wr_i && (bus_addr_i == `DTWS_ADDR_WR_PORT);
   assign wr_sel = bus_wr_i && (bus_addr_i == `DTWS_ADDR_WR_SEL);
   assign rd_hit = bus_rd_i && (bus_addr_i == `DTWS_ADDR_RD_PORT
      || bus_addr_i == `DTWS_ADDR_RD_AUX);
   assign vert = sel_ff[`DTWS_SEL_HALF_BIT];
   assign host_tbl_wr = wr_port && vert && (sel_ff[2:0] == `DTWS_SUB_TBL_DATA);
   assign hp_idx = ptr_ff[9:1];

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sel_ff <= `DTWS_SEL_RST;
      end else if (wr_sel) begin
         sel_ff <= bus_data_i;
      end
   end

   // the horizontal half owns mode and pointer, the vertical half levels
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         mode_ff <= `DTWS_MODE_RST;
         thresh_ff <= `DTWS_THRESH_RST;
         kofs_ff <= `DTWS_KOFS_RST;
      end else if (wr_port) begin
         unique case (sel_ff[2:0])
            `DTWS_SUB_MODE: begin
               if (!vert) begin
                  mode_ff <= bus_data_i;
               end
            end
            `DTWS_SUB_THRESH: begin
               if (vert) begin
                  thresh_ff <= bus_data_i;
               end
            end
            `DTWS_SUB_KOFS: begin
               if (vert) begin
                  kofs_ff <= bus_data_i;
               end
            end
            default: begin
               mode_ff <= mode_ff;
            end
         endcase
      end
   end

   // pointer steps after each table data access so tables stream out
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ptr_ff <= 10'h000;
      end else if (wr_port && !vert && sel_ff[2:0] == `DTWS_SUB_PTR_LO) begin
         ptr_ff <= {ptr_ff[9:8], bus_data_i};
      end else if (wr_port && !vert && sel_ff[2:0] == `DTWS_SUB_PTR_HI) begin
         ptr_ff <= {bus_data_i[1:0], ptr_ff[7:0]};
      end else if (host_tbl_wr || (rd_hit && vert && bus_addr_i == `DTWS_ADDR_RD_PORT)) begin
         ptr_ff <= (ptr_ff == `DTWS_DISP_LAST) ? 10'h000 : 10'(ptr_ff + 10'h001);
      end
   end

   // read data answers on the cycle after the strobe, from flops
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_ff <= 8'h00;
         oe_ff <= 1'b0;
      end else begin
         oe_ff <= rd_hit;
         if (rd_hit) begin
            if (bus_addr_i == `DTWS_ADDR_RD_PORT) begin
               rdata_ff <= vert ? (ptr_ff[0] ? mem_b[hp_idx] : mem_a[hp_idx])
                  : sweep_x_i[7:0];
            end else begin
               rdata_ff <= vert ? thresh_ff : {3'h0, mode_ff[4:0]};
            end
         end
      end
   end
   assign bus_data_o = rdata_ff;
   assign bus_data_oe_o = oe_ff;

   ////////////////////////////////////////////////////////////////////////////
   // table writer: even positions feed table A, odd positions table B
   assign freeze = mode_ff[`DTWS_MODE_FREEZE_A] || mode_ff[`DTWS_MODE_DIFF];
   // host table loads take priority; the buffer absorbs the stall
   assign wr_if.ready = !host_tbl_wr;
   assign wr_accept = wr_if.valid && wr_if.ready;
   assign wr_idx = wr_if.x[9:1];
   assign old_a = mem_a[wr_idx];
   assign old_b = mem_b[wr_idx];
   assign wa_en = wr_accept && !wr_if.x[0] && !freeze;
   assign wb_en = wr_accept && wr_if.x[0];
   assign new_a = (mode_ff[`DTWS_MODE_MAXHOLD] && old_a > wr_if.y) ? old_a : wr_if.y;
   assign new_b = (mode_ff[`DTWS_MODE_MAXHOLD] && old_b > wr_if.y) ? old_b : wr_if.y;

   // two separate arrays so both tables can be read in the same cycle
   always_ff @(posedge clk_i) begin
      if (host_tbl_wr && !ptr_ff[0]) begin
         mem_a[hp_idx] <= bus_data_i;
      end else if (wa_en) begin
         mem_a[wr_idx] <= new_a;
      end
   end

   always_ff @(posedge clk_i) begin
      if (host_tbl_wr && ptr_ff[0]) begin
         mem_b[hp_idx] <= bus_data_i;
      end else if (wb_en) begin
         mem_b[wr_idx] <= new_b;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // display scan, stepped from the 1 MHz processor tick
   assign tick = (tick_cnt_ff == 7'(`DTWS_PHI2_CYC - 1));
   assign pause = (dcnt_ff == sweep_x_i);

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         tick_cnt_ff <= 7'h00;
      end else begin
         tick_cnt_ff <= tick ? 7'h00 : 7'(tick_cnt_ff + 7'h01);
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         dcnt_ff <= 10'h000;
         trace_ff <= 1'b0;
      end else if (tick && !pause) begin
         if (dcnt_ff == `DTWS_DISP_LAST) begin
            dcnt_ff <= 10'h000;
            trace_ff <= !trace_ff;
         end else begin
            dcnt_ff <= 10'(dcnt_ff + 10'h001);
         end
      end
   end

   assign d_idx = dcnt_ff[9:1];
   assign da = mem_a[d_idx];
   assign db = mem_b[d_idx];
   // sign in bit 9 or overflow in bit 8 means the point is off screen
   assign diff = 10'({2'h0, db} - {2'h0, da} + {2'h0, kofs_ff});

   always_comb begin
      nxt_disp_x = dcnt_ff;
      nxt_disp_y = 8'h00;
      nxt_blank = 1'b0;
      if (cursor_cycle_i) begin
         nxt_disp_y = thresh_ff;
      end else if (mode_ff[`DTWS_MODE_DIFF]) begin
         nxt_disp_y = diff[7:0];
         nxt_blank = (diff[9:8] != 2'h0);
      end else if (mode_ff[`DTWS_MODE_SHOW_A] && mode_ff[`DTWS_MODE_SHOW_B]) begin
         if (mode_ff[`DTWS_MODE_FREEZE_A]) begin
            nxt_disp_y = trace_ff ? db : da;
         end else begin
            nxt_disp_y = dcnt_ff[0] ? db : da;
         end
      end else if (mode_ff[`DTWS_MODE_SHOW_A]) begin
         nxt_disp_y = da;
      end else if (mode_ff[`DTWS_MODE_SHOW_B]) begin
         nxt_disp_y = db;
      end else begin
         nxt_blank = 1'b1;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         disp_x_o <= 10'h000;
         disp_y_o <= 8'h00;
         disp_blank_o <= 1'b1;
         disp_trace_o <= 1'b0;
         disp_pause_o <= 1'b0;
      end else begin
         disp_x_o <= nxt_disp_x;
         disp_y_o <= nxt_disp_y;
         disp_blank_o <= nxt_blank;
         disp_trace_o <= trace_ff && mode_ff[`DTWS_MODE_FREEZE_A];
         disp_pause_o <= pause;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   property p_b_every;
      @(posedge clk_i) disable iff (rst_i)
      (wb_en && !host_tbl_wr && !mode_ff[`DTWS_MODE_MAXHOLD])
         |=> mem_b[$past(wr_idx)] == $past(wr_if.y);
   endproperty
   a_b_every: assert property (p_b_every) else $error("table B not rewritten");

   property p_freeze;
      @(posedge clk_i) disable iff (rst_i)
      (wr_accept && !wr_if.x[0] && freeze && !host_tbl_wr)
         |=> mem_a[$past(wr_idx)] == $past(old_a);
   endproperty
   a_freeze: assert property (p_freeze) else $error("frozen table A changed");

   property p_maxhold;
      @(posedge clk_i) disable iff (rst_i)
      (wb_en && mode_ff[`DTWS_MODE_MAXHOLD])
         |=> (mem_b[$past(wr_idx)] >= $past(old_b));
   endproperty
   a_maxhold: assert property (p_maxhold) else $error("max hold lost a peak");

   property p_cursor;
      @(posedge clk_i) disable iff (rst_i)
      cursor_cycle_i |=> (disp_y_o == $past(thresh_ff) && !disp_blank_o);
   endproperty
   a_cursor: assert property (p_cursor) else $error("cursor level not shown");

   property p_pause;
      @(posedge clk_i) disable iff (rst_i)
      (tick && pause) |=> $stable(dcnt_ff) ##1 disp_x_o == $past(dcnt_ff, 2);
   endproperty
   a_pause: assert property (p_pause) else $error("scan moved at update point");

   property p_decode;
      @(posedge clk_i) disable iff (rst_i)
      (bus_rd_i && bus_addr_i != `DTWS_ADDR_RD_PORT && bus_addr_i != `DTWS_ADDR_RD_AUX)
         |=> !bus_data_oe_o;
   endproperty
   a_decode: assert property (p_decode) else $error("unmapped read answered");

   property p_subaddr;
      @(posedge clk_i) disable iff (rst_i)
      (wr_port && vert && sel_ff[2:0] == `DTWS_SUB_THRESH)
         |=> (thresh_ff == $past(bus_data_i) && $stable(mode_ff));
   endproperty
   a_subaddr: assert property (p_subaddr) else $error("subaddress write misrouted");

   property p_diff;
      @(posedge clk_i) disable iff (rst_i)
      (mode_ff[`DTWS_MODE_DIFF] && !cursor_cycle_i && diff[9:8] == 2'h0)
         |=> (disp_y_o == $past(diff[7:0]) && !disp_blank_o);
   endproperty
   a_diff: assert property (p_diff) else $error("difference display wrong");
endmodule // dtws_top

//--- tb/dtws_host_mdl.sv
// dtws_host_mdl.sv: instrument microcomputer model, one byte per bus strobe
// assumes: strobes move on falling edges, read answer comes one cycle after the strobe
`timescale 1ns/10ps
module dtws_host_mdl (
   input wire logic clk_i,
   input wire logic [7:0] rdata_i,
   input wire logic oe_i,
   output logic [7:0] addr_o,
   output logic [7:0] wdata_o,
   output logic wr_o,
   output logic rd_o
);
   initial begin
      addr_o = 8'h00;
      wdata_o = 8'h00;
      wr_o = 1'b0;
      rd_o = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // released lines show the inverse so a stale byte can never pass for a match
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_i);
      addr_o = a;
      wdata_o = d;
      wr_o = 1'b1;
      @(negedge clk_i);
      wr_o = 1'b0;
      addr_o = ~a;
      wdata_o = ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok,
                     output logic ok2);
      @(negedge clk_i);
      addr_o = a;
      rd_o = 1'b1;
      @(negedge clk_i);
      rd_o = 1'b0;
      addr_o = ~a;
      d = rdata_i;
      ok = oe_i;
      @(negedge clk_i);
      ok2 = oe_i;
   endtask
endmodule // dtws_host_mdl

//--- tb/tb.sv
// tb.sv: self-checking bench for the dual-table waveform storage top
// assumes: host model owns the bus, bench drives sweep and samples on falling edges
`timescale 1ns/10ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fails++; \
   $display("ERROR %0t got %0h exp %0h", $time, a, b); end end
module tb;
   logic clk_i, rst_i, smp_valid_i, pas, cursor, wr, rd, oe, ok, ok2, blank, trace, pause;
   logic [9:0] sweep_x_i, dx, px;
   logic [7:0] smp_y_i, addr, wdat, rdat, dy, d, th, a0, a1, b0, b1, s;
   logic [7:0] v [3];
   logic [8:0] ex;
   int fails = 0;
   int tests_run = 0;
   int n;
   dtws_top dut (.clk_i(clk_i), .rst_i(rst_i), .bus_addr_i(addr), .bus_data_i(wdat),
      .bus_wr_i(wr), .bus_rd_i(rd), .bus_data_o(rdat), .bus_data_oe_o(oe),
      .sweep_x_i(sweep_x_i), .smp_valid_i(smp_valid_i), .smp_y_i(smp_y_i),
      .peak_average_select_i(pas), .cursor_cycle_i(cursor), .disp_x_o(dx),
      .disp_y_o(dy), .disp_blank_o(blank), .disp_trace_o(trace), .disp_pause_o(pause));
   dtws_host_mdl host (.clk_i(clk_i), .rdata_i(rdat), .oe_i(oe), .addr_o(addr),
      .wdata_o(wdat), .wr_o(wr), .rd_o(rd));
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] mean2(input logic [7:0] a, input logic [7:0] b);
      logic [8:0] t;
      t = {1'b0, a} + {1'b0, b};
      return t[8:1];
   endfunction
   function automatic logic [7:0] mx(input logic [7:0] a, input logic [7:0] b);
      return (a > b) ? a : b;
   endfunction
   // difference point: b minus a plus offset, blanked when off screen
   function automatic logic [8:0] dif(input logic [7:0] a, input logic [7:0] b,
                                      input logic [7:0] k);
      int t;
      t = int'(b) - int'(a) + int'(k);
      return {(t < 0 || t > 255), 8'(t)};
   endfunction
   task automatic sel_wr(input logic [7:0] sl, input logic [7:0] dd);
      host.wr(8'h7B, sl);
      host.wr(8'h7A, dd);
   endtask
   // leaves the vertical half on table data so FA reads and 7A writes hit the tables
   task automatic ptr(input logic [9:0] p);
      sel_wr(8'h03, p[7:0]);
      sel_wr(8'h04, {6'h00, p[9:8]});
      host.wr(8'h7B, 8'h85);
   endtask
   task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
      host.rd(a, d, ok, ok2);
      `CHK(ok, 1'b1)
      `CHK(d, e)
      `CHK(ok2, 1'b0)
   endtask
   // scan is held still by the update marker, so the shown point is fixed
   task automatic chk_mode(input logic [7:0] m, input logic [7:0] ey, input logic eb);
      sel_wr(8'h00, m);
      repeat (2) @(negedge clk_i);
      `CHK(blank, eb)
      if (!eb) `CHK(dy, ey)
   endtask
   // two samples per position, spaced wider than one reduction
   task automatic pos(input logic [9:0] x, input logic [7:0] y0, input logic [7:0] y1,
                      input logic p);
      for (int i = 0; i < 2; i++) begin
         @(negedge clk_i);
         sweep_x_i = x;
         smp_y_i = (i == 0) ? y0 : y1;
         pas = p;
         smp_valid_i = 1'b1;
         @(negedge clk_i);
         smp_valid_i = 1'b0;
         smp_y_i = ~smp_y_i;
         repeat (11) @(negedge clk_i);
      end
   endtask
   task automatic done(input string nm);
      $display("test %s done", nm);
   endtask
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge clk_i);
      fails++;
      $display("ERROR %0t watchdog expired", $time);
      summarize();
   end
   initial begin
      rst_i = 1'b1;
      sweep_x_i = 10'h000;
      smp_valid_i = 1'b0;
      smp_y_i = 8'h00;
      pas = 1'b0;
      cursor = 1'b0;
      void'($urandom(32'hF1CF));
      repeat (6) @(posedge clk_i);
      @(negedge clk_i);
      rst_i = 1'b0;
      `CHK(oe, 1'b0)
      th = 8'($urandom);
      sel_wr(8'h81, th);
      chk_rd(8'hFB, th);
      done("threshold");
      foreach (v[i]) begin
         host.rd(8'h7C + 8'(i * 64), d, ok, ok2);
         `CHK(ok, 1'b0)
      end
      host.wr(8'h7C, ~th);
      sel_wr(8'h01, ~th);
      host.wr(8'h7B, 8'h81);
      chk_rd(8'hFB, th);
      sel_wr(8'h00, 8'h07);
      chk_rd(8'hFB, 8'h07);
      done("decode");
      ptr(10'd998);
      foreach (v[i]) begin
         v[i] = 8'($urandom);
         host.wr(8'h7A, v[i]);
      end
      ptr(10'd998);
      foreach (v[i]) chk_rd(8'hFA, v[i]);
      done("tables");
      sel_wr(8'h00, 8'h03);
      a0 = 8'($urandom_range(0, 127));
      a1 = a0 + 8'(2 * $urandom_range(0, 63));
      b0 = 8'($urandom);
      b1 = 8'($urandom);
      pos(10'd4, a0, a1, 1'b0);
      pos(10'd5, b0, b1, 1'b1);
      pos(10'd6, b1, b0, 1'b0);
      repeat (40) @(negedge clk_i);
      ptr(10'd4);
      chk_rd(8'hFA, mean2(a0, a1));
      chk_rd(8'hFA, mx(b0, b1));
      done("reduction");
      sel_wr(8'h00, 8'h07);
      pos(10'd4, b0, b0, 1'b1);
      pos(10'd5, a0, a0, 1'b1);
      pos(10'd6, a1, a1, 1'b1);
      repeat (40) @(negedge clk_i);
      ptr(10'd4);
      chk_rd(8'hFA, mean2(a0, a1));
      chk_rd(8'hFA, a0);
      s = 8'($urandom);
      sel_wr(8'h00, 8'h13);
      pos(10'd5, s, s, 1'b1);
      pos(10'd6, s, s, 1'b1);
      repeat (40) @(negedge clk_i);
      ptr(10'd5);
      chk_rd(8'hFA, mx(a0, s));
      done("freeze and hold");
      cursor = 1'b1;
      repeat (3) @(negedge clk_i);
      `CHK(dy, th)
      cursor = 1'b0;
      sweep_x_i = 10'd999;
      for (int k = 0; k < 2; k++) begin
         px = dx;
         n = 0;
         while (dx === px && n < 300) begin
            @(negedge clk_i);
            n++;
         end
      end
      `CHK(n, 125)
      px = dx;
      sweep_x_i = px;
      repeat (260) @(negedge clk_i);
      `CHK(pause, 1'b1)
      `CHK(dx, px)
      done("display");
      a0 = 8'($urandom_range(128, 255));
      b0 = 8'($urandom_range(0, 127));
      ptr({px[9:1], 1'b0});
      host.wr(8'h7A, a0);
      host.wr(8'h7A, b0);
      sel_wr(8'h82, 8'hFF);
      ex = dif(a0, b0, 8'hFF);
      chk_mode(8'h08, ex[7:0], ex[8]);
      sel_wr(8'h82, 8'h00);
      ex = dif(a0, b0, 8'h00);
      chk_mode(8'h08, ex[7:0], ex[8]);
      chk_mode(8'h01, a0, 1'b0);
      chk_mode(8'h02, b0, 1'b0);
      chk_mode(8'h03, px[0] ? b0 : a0, 1'b0);
      chk_mode(8'h07, a0, 1'b0);
      `CHK(trace, 1'b0)
      chk_mode(8'h00, 8'h00, 1'b1);
      done("modes");
      summarize();
   end
endmodule // tb
